//--- src/mpe_checker.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE1] Circular supplemental axis feed above max interpolation rate gives 002C.
// [RULE2] Traverse feed above max interpolation rate gives 002C.
// [RULE3] Two-step speed with second reference not below first gives 002D.
// [RULE4] Interrupt feed seeing no interrupt input gives 002E.
// [RULE5] Interrupt feed with reversed travel directions gives 002F.
// [RULE6] Circular command with negative rotation count gives 0030.
// [RULE7] Traverse with bad feed, end or total winding counts gives 0030.
// [RULE8] Traverse rotating axis first or third not unlimited gives 0031.
// [RULE9] Indirect auxiliary output code outside 0 to 255 gives 0032.
// [RULE10] Continue after axis error during traverse is refused with 0033.
// [RULE11] Continue after axis moved while traverse stopped gives 0033.
// [RULE12] Continue only after clean deceleration stop, else restart needed.
// [RULE13] No host answer to auxiliary output code gives 0034.
// [RULE14] Host must acknowledge every auxiliary output code notification.
// [RULE15] Errors set status bit 14 and post hex code in next word.
// [RULE16] First error latched and held until host error reset.
module mpe_checker #(
  parameter int AUX_TIMEOUT = mpe_pkg::AUX_TIMEOUT_CYC,
  parameter int INT_WINDOW = mpe_pkg::INT_WINDOW_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire mpe_pkg::mpe_cmd_bus_t cmd_i,
  input wire logic signed [31:0] max_interp_rate_i,
  input wire logic [mpe_pkg::NUM_AXES-1:0] axis_unlimited_i,
  input wire logic interrupt_in_i,
  input wire logic host_ack_i,
  input wire logic axis_error_i,
  input wire logic axis_moved_i,
  input wire logic decel_stop_done_i,
  input wire logic program_restart_i,
  input wire logic error_reset_i,
  output logic [15:0] status_word_o,
  output logic [15:0] error_code_o,
  output logic decel_stop_o,
  output logic aux_notify_o,
  output logic [7:0] aux_code_o,
  output logic continue_ok_o
);
  localparam int TW = 22;

  typedef struct packed {
    mpe_pkg::mpe_state_t state;
    mpe_pkg::mpe_trv_t trv;
    logic err_flag;
    logic [15:0] code;
    logic decel;
    logic aux_notify;
    logic [7:0] aux_code;
    logic dir_no_int;
    logic dir_with_int;
    logic cont_ok;
  } mpe_st_t;

  mpe_st_t r;
  mpe_st_t next_r;
  logic [15:0] found;
  logic tmr_start;
  logic tmr_run;
  logic [TW-1:0] tmr_limit;
  logic tmr_expired;
  logic axis_ok;

  mpe_timer #(
    .WIDTH(TW)
  ) u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(tmr_start),
    .run_i(tmr_run),
    .limit_i(tmr_limit),
    .expired_o(tmr_expired)
  );

  // ****************************************
  // Command checks
  // ****************************************
  always_comb begin
    found = mpe_pkg::CODE_NONE;
    axis_ok = 1'b0;
    if (cmd_i.axis_sel == 2'(mpe_pkg::TRAVERSE_AXIS_A)
        || cmd_i.axis_sel == 2'(mpe_pkg::TRAVERSE_AXIS_B)) begin
      axis_ok = axis_unlimited_i[cmd_i.axis_sel];
    end
    if (cmd_i.valid) begin
      case (cmd_i.kind)
        mpe_pkg::MPE_CMD_CIRCULAR_CW, mpe_pkg::MPE_CMD_CIRCULAR_CCW: begin
          if (cmd_i.feed_rate > max_interp_rate_i) begin
            found = mpe_pkg::CODE_SUP_SPEED; // [RULE1]
          end else if (cmd_i.rotations < 0) begin
            found = mpe_pkg::CODE_NEG_ROTATION; // [RULE6]
          end
        end
        mpe_pkg::MPE_CMD_TWO_STEP: begin
          if (cmd_i.speed_ref_2 >= cmd_i.speed_ref_1) begin
            found = mpe_pkg::CODE_SECOND_SPEED; // [RULE3]
          end
        end
        mpe_pkg::MPE_CMD_INTERRUPT_FEED: begin
          if (cmd_i.dir_no_int != cmd_i.dir_with_int) begin
            found = mpe_pkg::CODE_REVERSE; // [RULE5]
          end
        end
        mpe_pkg::MPE_CMD_TRAVERSE: begin
          if (cmd_i.feed_rate <= 0 || cmd_i.end_windings < 0
              || cmd_i.total_windings <= 0) begin
            found = mpe_pkg::CODE_NEG_ROTATION; // [RULE7]
          end else if (cmd_i.feed_rate > max_interp_rate_i) begin
            found = mpe_pkg::CODE_SUP_SPEED; // [RULE2]
          end else if (!axis_ok) begin
            found = mpe_pkg::CODE_AXIS_CONFIG; // [RULE8]
          end
        end
        mpe_pkg::MPE_CMD_AUX_CODE: begin
          if (cmd_i.aux_indirect && (cmd_i.aux_value < 0
              || cmd_i.aux_value > mpe_pkg::AUX_CODE_MAX)) begin
            found = mpe_pkg::CODE_AUX_RANGE; // [RULE9]
          end
        end
        mpe_pkg::MPE_CMD_CONTINUE: begin
          if (r.trv != mpe_pkg::MPE_TRV_HELD) begin
            found = mpe_pkg::CODE_CONTINUE; // [RULE10]
          end
        end
        default: begin
          found = mpe_pkg::CODE_NONE;
        end
      endcase
    end
  end

  // ****************************************
  // Sequencing and error latch
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.aux_notify = 1'b0;
    next_r.cont_ok = 1'b0;
    tmr_start = 1'b0;
    tmr_run = 1'b0;
    tmr_limit = TW'(AUX_TIMEOUT);
    case (r.state)
      mpe_pkg::MPE_IDLE: begin
        if (cmd_i.valid && found == mpe_pkg::CODE_NONE) begin
          if (cmd_i.kind == mpe_pkg::MPE_CMD_INTERRUPT_FEED) begin
            next_r.state = mpe_pkg::MPE_INT_WAIT;
            tmr_start = 1'b1;
            tmr_limit = TW'(INT_WINDOW);
          end else if (cmd_i.kind == mpe_pkg::MPE_CMD_AUX_CODE) begin
            next_r.state = mpe_pkg::MPE_AUX_WAIT;
            next_r.aux_notify = 1'b1;
            next_r.aux_code = cmd_i.aux_value[7:0];
            tmr_start = 1'b1;
          end else if (cmd_i.kind == mpe_pkg::MPE_CMD_TRAVERSE) begin
            next_r.trv = mpe_pkg::MPE_TRV_RUN;
          end else if (cmd_i.kind == mpe_pkg::MPE_CMD_CONTINUE) begin
            next_r.trv = mpe_pkg::MPE_TRV_RUN; // [RULE12]
            next_r.cont_ok = 1'b1;
          end
        end
      end
      mpe_pkg::MPE_INT_WAIT: begin
        tmr_run = 1'b1;
        if (interrupt_in_i) begin
          next_r.state = mpe_pkg::MPE_IDLE;
        end else if (tmr_expired) begin
          next_r.state = mpe_pkg::MPE_IDLE; // [RULE4]
        end
      end
      mpe_pkg::MPE_AUX_WAIT: begin
        tmr_run = 1'b1;
        if (host_ack_i) begin
          next_r.state = mpe_pkg::MPE_IDLE; // [RULE14]
        end else if (tmr_expired) begin
          next_r.state = mpe_pkg::MPE_IDLE; // [RULE13]
        end
      end
      default: begin
        next_r.state = mpe_pkg::MPE_IDLE;
      end
    endcase
    // Traverse hold tracking
    if (r.trv == mpe_pkg::MPE_TRV_RUN) begin
      if (axis_error_i) begin
        next_r.trv = mpe_pkg::MPE_TRV_BROKEN; // [RULE10]
      end else if (decel_stop_done_i) begin
        next_r.trv = mpe_pkg::MPE_TRV_HELD; // [RULE12]
      end
    end else if (r.trv == mpe_pkg::MPE_TRV_HELD) begin
      if (axis_error_i || axis_moved_i) begin
        next_r.trv = mpe_pkg::MPE_TRV_BROKEN; // [RULE11]
      end
    end
    if (program_restart_i) begin
      next_r.trv = mpe_pkg::MPE_TRV_NONE;
    end
    if (error_reset_i) begin
      next_r.err_flag = 1'b0;
      next_r.code = mpe_pkg::CODE_NONE;
      next_r.decel = 1'b0;
    end
    // Detection wins over a same-cycle reset; first error kept
    if (!r.err_flag || error_reset_i) begin
      if (r.state == mpe_pkg::MPE_IDLE && found != mpe_pkg::CODE_NONE) begin
        next_r.err_flag = 1'b1; // [RULE15]
        next_r.code = found;
        next_r.decel = 1'b1;
      end else if (r.state == mpe_pkg::MPE_INT_WAIT && !interrupt_in_i && tmr_expired) begin
        next_r.err_flag = 1'b1; // [RULE4]
        next_r.code = mpe_pkg::CODE_NO_INTERRUPT;
        next_r.decel = 1'b1;
      end else if (r.state == mpe_pkg::MPE_AUX_WAIT && !host_ack_i && tmr_expired) begin
        next_r.err_flag = 1'b1; // [RULE13]
        next_r.code = mpe_pkg::CODE_AUX_TIMEOUT;
        next_r.decel = 1'b1;
      end
    end else begin
      next_r.code = r.code; // [RULE16]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ****************************************
  // Output flops
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      status_word_o <= mpe_pkg::STATUS_RESET;
      error_code_o <= mpe_pkg::CODE_NONE;
      decel_stop_o <= 1'b0;
      aux_notify_o <= 1'b0;
      aux_code_o <= 8'h00;
      continue_ok_o <= 1'b0;
    end else begin
      status_word_o <= mpe_pkg::STATUS_RESET;
      status_word_o[mpe_pkg::ERR_FLAG_BIT] <= next_r.err_flag; // [RULE15]
      error_code_o <= next_r.code; // [RULE15]
      decel_stop_o <= next_r.decel;
      aux_notify_o <= next_r.aux_notify;
      aux_code_o <= next_r.aux_code;
      continue_ok_o <= next_r.cont_ok;
    end
  end
endmodule

//--- src/mpe_pkg.sv
package mpe_pkg;
  // ****************************************
  // Error codes
  // ****************************************
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_SUP_SPEED = 16'h002C;
  localparam logic [15:0] CODE_SECOND_SPEED = 16'h002D;
  localparam logic [15:0] CODE_NO_INTERRUPT = 16'h002E;
  localparam logic [15:0] CODE_REVERSE = 16'h002F;
  localparam logic [15:0] CODE_NEG_ROTATION = 16'h0030;
  localparam logic [15:0] CODE_AXIS_CONFIG = 16'h0031;
  localparam logic [15:0] CODE_AUX_RANGE = 16'h0032;
  localparam logic [15:0] CODE_CONTINUE = 16'h0033;
  localparam logic [15:0] CODE_AUX_TIMEOUT = 16'h0034;
  // ****************************************
  // Status word and limits
  // ****************************************
  localparam int ERR_FLAG_BIT = 14;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic signed [31:0] AUX_CODE_MAX = 32'sh0000_00FF;
  localparam int AUX_TIMEOUT_MS = 100;
  localparam int CLK_HZ = 25000000;
  localparam int AUX_TIMEOUT_CYC = (AUX_TIMEOUT_MS * (CLK_HZ / 1000));
  localparam int INT_WINDOW_US = 100;
  localparam int INT_WINDOW_CYC = (INT_WINDOW_US * (CLK_HZ / 1000000));
  localparam int NUM_AXES = 4;
  localparam int TRAVERSE_AXIS_A = 0;
  localparam int TRAVERSE_AXIS_B = 2;

  // ****************************************
  // Command kinds
  // ****************************************
  typedef enum logic [2:0] {
    MPE_CMD_NONE = 3'h0,
    MPE_CMD_CIRCULAR_CW = 3'h1,
    MPE_CMD_CIRCULAR_CCW = 3'h2,
    MPE_CMD_TWO_STEP = 3'h3,
    MPE_CMD_INTERRUPT_FEED = 3'h4,
    MPE_CMD_TRAVERSE = 3'h5,
    MPE_CMD_AUX_CODE = 3'h6,
    MPE_CMD_CONTINUE = 3'h7
  } mpe_cmd_t;

  typedef struct packed {
    logic valid;
    mpe_cmd_t kind;
    logic signed [31:0] feed_rate;
    logic signed [31:0] speed_ref_1;
    logic signed [31:0] speed_ref_2;
    logic signed [31:0] rotations;
    logic signed [31:0] end_windings;
    logic signed [31:0] total_windings;
    logic signed [31:0] aux_value;
    logic aux_indirect;
    logic [1:0] axis_sel;
    logic dir_no_int;
    logic dir_with_int;
  } mpe_cmd_bus_t;

  typedef enum logic [1:0] {
    MPE_IDLE = 2'b00,
    MPE_INT_WAIT = 2'b01,
    MPE_AUX_WAIT = 2'b11
  } mpe_state_t;

  typedef enum logic [1:0] {
    MPE_TRV_NONE = 2'b00,
    MPE_TRV_RUN = 2'b01,
    MPE_TRV_HELD = 2'b11,
    MPE_TRV_BROKEN = 2'b10
  } mpe_trv_t;
endpackage

//--- src/mpe_timer.sv
`timescale 1ns/1ps
module mpe_timer #(
  parameter int WIDTH = 22
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic run_i,
  input wire logic [WIDTH-1:0] limit_i,
  output logic expired_o
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic expired;
  } mpe_timer_st_t;

  mpe_timer_st_t r;
  mpe_timer_st_t next_r;

  // ****************************************
  // Down counter, pulse on reaching zero
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.expired = 1'b0;
    if (start_i) begin
      next_r.count = limit_i;
    end else if (run_i && r.count != '0) begin
      next_r.count = r.count - 1'b1;
      if (r.count == {{(WIDTH-1){1'b0}}, 1'b1}) begin
        next_r.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign expired_o = r.expired;
endmodule

//--- verification/mpe_checker_bench.sv
`timescale 1ns/1ps
module mpe_checker_bench;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic mclk_i = 1'b0, rst_n_i = 1'b0, interrupt_in_i = 1'b0, host_ack_i;
  logic axis_error_i = 1'b0, axis_moved_i = 1'b0, decel_stop_done_i = 1'b0;
  logic program_restart_i = 1'b0, error_reset_i = 1'b0, mute = 1'b0, slow = 1'b0;
  logic decel_stop_o, aux_notify_o, continue_ok_o, seen_ok;
  logic [15:0] status_word_o, error_code_o;
  logic [7:0] aux_code_o;
  logic [3:0] unlimited = 4'h1;
  mpe_pkg::mpe_cmd_bus_t cmd_i = '0;
  int failures = 0;
  int checked = 0;
  mpe_checker #(.AUX_TIMEOUT(20), .INT_WINDOW(20)) mpe_checker_i (.mclk_i, .rst_n_i, .cmd_i,
    .max_interp_rate_i(32'sh0000_03E8), .axis_unlimited_i(unlimited), .interrupt_in_i, .host_ack_i,
    .axis_error_i, .axis_moved_i, .decel_stop_done_i, .program_restart_i, .error_reset_i,
    .status_word_o, .error_code_o, .decel_stop_o, .aux_notify_o, .aux_code_o, .continue_ok_o);
  mpe_host_model mpe_host_model_i (.mclk_i, .aux_notify_i(aux_notify_o), .mute_i(mute),
    .slow_i(slow), .host_ack_o(host_ack_i));
  initial forever #20 mclk_i = ~mclk_i;
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    step(1);
    sig = 1'b0;
    step(1);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input mpe_pkg::mpe_cmd_t k, input logic signed [31:0] a, b, c,
                     input logic [1:0] s, input logic [15:0] exp);
    cmd_i = '{valid:1'b1, kind:k, feed_rate:a, speed_ref_1:a, speed_ref_2:b, rotations:b,
      end_windings:b, total_windings:c, aux_value:a, aux_indirect:s[0], axis_sel:s,
      dir_no_int:s[0], dir_with_int:s[1]};
    step(1);
    cmd_i.valid = 1'b0;
    seen_ok = continue_ok_o;
    for (int i = 0; i < 40 && status_word_o[14] !== 1'b1; i++) begin
      seen_ok |= continue_ok_o;
      step(1);
    end
    check(error_code_o, exp);
    check(status_word_o, (exp != 16'h0000) ? 16'h4000 : 16'h0000);
    check({15'h0000, seen_ok}, 16'(k == mpe_pkg::MPE_CMD_CONTINUE && exp == 0));
    pulse(error_reset_i);
  endtask
  task automatic t_circ;
    run(mpe_pkg::MPE_CMD_CIRCULAR_CW, 1001, 1, 0, 0, 16'h002C);
    run(mpe_pkg::MPE_CMD_CIRCULAR_CCW, 1000, -1, 0, 0, 16'h0030);
    run(mpe_pkg::MPE_CMD_CIRCULAR_CW, 2000, -1, 0, 0, 16'h002C);
    run(mpe_pkg::MPE_CMD_CIRCULAR_CW, 1000, 0, 0, 0, 16'h0000);
  endtask
  task automatic t_two;
    run(mpe_pkg::MPE_CMD_TWO_STEP, 500, 500, 0, 0, 16'h002D);
    run(mpe_pkg::MPE_CMD_TWO_STEP, 500, 501, 0, 0, 16'h002D);
    run(mpe_pkg::MPE_CMD_TWO_STEP, 500, 499, 0, 0, 16'h0000);
  endtask
  task automatic t_int;
    run(mpe_pkg::MPE_CMD_INTERRUPT_FEED, 100, 0, 0, 0, 16'h002E);
    interrupt_in_i = 1'b1;
    run(mpe_pkg::MPE_CMD_INTERRUPT_FEED, 100, 0, 0, 2'b01, 16'h002F);
    run(mpe_pkg::MPE_CMD_INTERRUPT_FEED, 100, 0, 0, 2'b11, 16'h0000);
    interrupt_in_i = 1'b0;
  endtask
  task automatic t_trv;
    run(mpe_pkg::MPE_CMD_TRAVERSE, 0, 0, 5, 0, 16'h0030);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 100, -1, 5, 0, 16'h0030);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 100, 0, 0, 0, 16'h0030);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 1001, 0, 5, 0, 16'h002C);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 100, 0, 5, 2'd2, 16'h0031);
    unlimited = 4'hF;
    run(mpe_pkg::MPE_CMD_TRAVERSE, 100, 0, 5, 2'd1, 16'h0031);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 100, 0, 5, 2'd2, 16'h0000);
    unlimited = 4'h1;
  endtask
  task automatic t_cont;
    pulse(program_restart_i);
    run(mpe_pkg::MPE_CMD_CONTINUE, 0, 0, 0, 0, 16'h0033);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 100, 0, 5, 0, 16'h0000);
    pulse(decel_stop_done_i);
    run(mpe_pkg::MPE_CMD_CONTINUE, 0, 0, 0, 0, 16'h0000);
    check({15'h0000, seen_ok}, 16'h0001);
    pulse(axis_error_i);
    run(mpe_pkg::MPE_CMD_CONTINUE, 0, 0, 0, 0, 16'h0033);
    pulse(program_restart_i);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 100, 0, 5, 0, 16'h0000);
    pulse(decel_stop_done_i);
    pulse(axis_moved_i);
    run(mpe_pkg::MPE_CMD_CONTINUE, 0, 0, 0, 0, 16'h0033);
  endtask
  task automatic t_aux;
    run(mpe_pkg::MPE_CMD_AUX_CODE, 256, 0, 0, 2'b01, 16'h0032);
    run(mpe_pkg::MPE_CMD_AUX_CODE, -1, 0, 0, 2'b01, 16'h0032);
    run(mpe_pkg::MPE_CMD_AUX_CODE, 255, 0, 0, 2'b01, 16'h0000);
    check({8'h00, aux_code_o}, 16'h00FF);
    slow = 1'b1;
    run(mpe_pkg::MPE_CMD_AUX_CODE, 5, 0, 0, 0, 16'h0000);
    mute = 1'b1;
    run(mpe_pkg::MPE_CMD_AUX_CODE, 0, 0, 0, 2'b01, 16'h0034);
    mute = 1'b0;
  endtask
  task automatic t_latch;
    cmd_i = '{valid:1'b1, kind:mpe_pkg::MPE_CMD_TWO_STEP, default:'0};
    step(1);
    cmd_i.valid = 1'b0;
    step(3);
    run(mpe_pkg::MPE_CMD_TRAVERSE, 0, 0, 5, 0, 16'h002D);
  endtask
  task automatic close_out;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    failures++;
    close_out;
  end
  initial begin
    step(8);
    rst_n_i = 1'b1;
    step(1);
    t_circ;
    t_two;
    t_int;
    t_trv;
    t_cont;
    t_aux;
    t_latch;
    close_out;
  end
endmodule

//--- verification/mpe_checker_chk.sv
`timescale 1ns/1ps
module mpe_checker_chk #(
  parameter int AUX_TIMEOUT = 20,
  parameter int INT_WINDOW = 20
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire mpe_pkg::mpe_cmd_bus_t cmd_i,
  input wire logic signed [31:0] max_interp_rate_i,
  input wire logic host_ack_i,
  input wire logic error_reset_i,
  input wire logic [15:0] status_word_o,
  input wire logic [15:0] error_code_o,
  input wire logic decel_stop_o,
  input wire logic aux_notify_o,
  input wire logic [7:0] aux_code_o,
  input wire logic continue_ok_o
);
  // ****************************************
  // Aux wait counter and sequences
  // ****************************************
  localparam int TMO = AUX_TIMEOUT + 3;
  int wait_cnt;
  logic flag;
  assign flag = status_word_o[mpe_pkg::ERR_FLAG_BIT];
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || host_ack_i || flag) begin
      wait_cnt <= 0;
    end else if (aux_notify_o) begin
      wait_cnt <= 1;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt + 1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence cmd_s(k);
    cmd_i.valid && cmd_i.kind == k && !decel_stop_o;
  endsequence
  sequence post_s(c);
    ##[1:2] (flag && error_code_o == c);
  endsequence
  two_step_a: assert property (cmd_s(mpe_pkg::MPE_CMD_TWO_STEP) ##0
    cmd_i.speed_ref_2 >= cmd_i.speed_ref_1 |-> post_s(16'h002D)) else $error("two-step");
  circ_rot_a: assert property (cmd_s(mpe_pkg::MPE_CMD_CIRCULAR_CCW) ##0 (cmd_i.rotations < 0
    && cmd_i.feed_rate <= max_interp_rate_i) |-> post_s(16'h0030)) else $error("rotation");
  trv_feed_a: assert property (cmd_s(mpe_pkg::MPE_CMD_TRAVERSE) ##0 (cmd_i.end_windings >= 0
    && cmd_i.total_windings > 0 && cmd_i.feed_rate > max_interp_rate_i) |-> post_s(16'h002C))
    else $error("traverse rate");
  aux_range_a: assert property (cmd_s(mpe_pkg::MPE_CMD_AUX_CODE) ##0 (cmd_i.aux_indirect
    && (cmd_i.aux_value > 255 || cmd_i.aux_value < 0)) |-> post_s(16'h0032)) else $error("aux range");
  aux_send_a: assert property (cmd_s(mpe_pkg::MPE_CMD_AUX_CODE) ##0 (cmd_i.aux_indirect
    && cmd_i.aux_value inside {[0:255]}) |=> (aux_notify_o && aux_code_o ==
    $past(cmd_i.aux_value[7:0]))) else $error("aux send");
  notify_pulse_a: assert property (aux_notify_o |=> !aux_notify_o) else $error("notify");
  aux_wait_a: assert property (wait_cnt <= TMO) else $error("aux timeout late");
  flag_code_a: assert property (flag == (error_code_o != 0) && decel_stop_o == flag
    && (status_word_o & 16'hBFFF) == 16'h0000) else $error("status word");
  code_hold_a: assert property (flag && !error_reset_i |=> $stable(error_code_o))
    else $error("code changed");
  clear_a: assert property (flag && error_reset_i && !cmd_i.valid |=> !flag)
    else $error("reset ignored");
  cont_pulse_a: assert property (continue_ok_o |-> !flag ##1 !continue_ok_o)
    else $error("continue pulse");
endmodule
bind mpe_checker mpe_checker_chk #(.AUX_TIMEOUT(AUX_TIMEOUT), .INT_WINDOW(INT_WINDOW))
  mpe_checker_chk_i (.mclk_i, .rst_n_i, .cmd_i, .max_interp_rate_i, .host_ack_i,
  .error_reset_i, .status_word_o, .error_code_o, .decel_stop_o, .aux_notify_o, .aux_code_o,
  .continue_ok_o);

//--- verification/mpe_host_model.sv
`timescale 1ns/1ps
module mpe_host_model (
  input wire logic mclk_i,
  input wire logic aux_notify_i,
  input wire logic mute_i,
  input wire logic slow_i,
  output logic host_ack_o
);
  // ****************************************
  // Host acknowledge, prompt or slow
  // ****************************************
  logic [7:0] pipe = 8'h00;
  always @(posedge mclk_i) begin
    pipe <= {pipe[6:0], aux_notify_i && !mute_i};
  end
  assign host_ack_o = slow_i ? pipe[7] : pipe[0];
endmodule
